// >>> wpm_regs.sv
// What this block does
// R1 - report three-bit oscillator trim code; 011b centre, eight 12 % steps
// R2 - config bits 7:4 give phase difference threshold for wake-up event
// R3 - config bit 3: trigger sample joins average when set, not when clear
// R4 - config bits 2:1 pick newest-sample weight 4, 8, 16 or 32
// R5 - config bit 0 picks reference: register when clear, average when set
// R6 - phase reference register, read-write at 38h space A, resets zero
// R7 - phase running average, read-only at 39h space A, resets zero
// R8 - latest phase result readable at 3Ah space A, resets zero
// R9 - amplitude running average, read-only at 35h space A, resets zero
// R10 - latest amplitude result readable at 36h space A, resets zero
// R11 - trim readout at 39h space B: bits 7:3 read zero, 2:0 code
// R12 - amplitude wake-up uses amplitude reference register when select clear
// R13 - amplitude reference register, read-write at 34h space A, resets zero
// R14 - each sample that R3 lets join moves average by (sample minus average) over weight
// R15 - wake-up event when |sample - reference| exceeds threshold
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wpm_regs
   import wpm_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire wpm_bus_t            bus_i,
   output logic      [7:0]          rd_data_o,
   input  wire wpm_meas_t           amp_meas_i,
   input  wire wpm_meas_t           phase_meas_i,
   input  wire logic [TRIM_W-1:0]   osc_trim_i,
   output logic                     amp_wake_o,
   output logic                     phase_wake_o
);

   function automatic logic hit(input logic [6:0] addr,
                                input logic       space,
                                input logic [5:0] off);
      hit = (addr[ADDR_SPACE_BIT] == space) && (addr[5:0] == off);
   endfunction

   // floor rounding on a negative step never overshoots the sample
   function automatic logic [7:0] avg_step(input logic [7:0] avg,
                                           input logic [7:0] smp,
                                           input logic [1:0] wgt);
      logic signed [8:0] diff;
      logic signed [8:0] step;
      logic        [2:0] sh;
      logic        [8:0] sum;
      diff = signed'({1'b0, smp}) - signed'({1'b0, avg});
      sh   = {1'b0, wgt} + WGT_SHIFT_BASE;
      step = diff >>> sh;
      sum  = {1'b0, avg} + unsigned'(step);
      avg_step = sum[7:0];
   endfunction

   function automatic logic beyond(input logic [7:0] smp,
                                   input logic [7:0] refv,
                                   input logic [3:0] delta);
      logic [7:0] mag;
      mag    = (smp >= refv) ? (smp - refv) : (refv - smp);
      beyond = mag > {4'h0, delta};
   endfunction

   wpm_meas_t          meas      [NUM_CH];
   wpm_cfg_t           cfg       [NUM_CH];
   logic [7:0]         cfg_q     [NUM_CH];
   logic [7:0]         ref_q     [NUM_CH];
   logic [7:0]         avg_q     [NUM_CH];
   logic [7:0]         res_q     [NUM_CH];
   logic [7:0]         ref_sel   [NUM_CH];
   logic [NUM_CH-1:0]  trig;
   logic [NUM_CH-1:0]  wake_q;
   logic [TRIM_W-1:0]  trim_q;
   logic [7:0]         rd_q;

   assign meas[CH_AMP]   = amp_meas_i;
   assign meas[CH_PHASE] = phase_meas_i;

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign cfg[ch] = wpm_cfg_t'(cfg_q[ch]);

      // field layout per channel [R2] [R3] [R4] [R5]
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg_q[ch] <= CFG_RST;
         end else if (bus_i.wr && hit(bus_i.addr, SPACE_A, OFF_CFG[ch])) begin
            cfg_q[ch] <= bus_i.wdata;
         end
      end

      // software reference [R6] [R13]
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ref_q[ch] <= REF_RST;
         end else if (bus_i.wr && hit(bus_i.addr, SPACE_A, OFF_REF[ch])) begin
            ref_q[ch] <= bus_i.wdata;
         end
      end

      // reference choice [R5] [R12]
      assign ref_sel[ch] = cfg[ch].src ? avg_q[ch] : ref_q[ch];

      // threshold compare [R2] [R15]
      assign trig[ch] = meas[ch].valid
                      && beyond(meas[ch].value, ref_sel[ch], cfg[ch].delta);

      // latest result [R8] [R10]
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            res_q[ch] <= RES_RST;
         end else if (meas[ch].valid) begin
            res_q[ch] <= meas[ch].value;
         end
      end

      // running average, trigger sample gated [R3] [R4] [R14] [R7] [R9]
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            avg_q[ch] <= AVG_RST;
         end else if (meas[ch].valid && (!trig[ch] || cfg[ch].incl)) begin
            avg_q[ch] <= avg_step(avg_q[ch], meas[ch].value, cfg[ch].weight);
         end
      end

      // one-cycle wake-up pulse per offending sample [R15]
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            wake_q[ch] <= 1'b0;
         end else begin
            wake_q[ch] <= trig[ch];
         end
      end
   end

   // trim code comes from calibration logic on this clock [R1]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_q <= TRIM_RST;
      end else begin
         trim_q <= osc_trim_i;
      end
   end

   // reads have no side effects; unmapped and idle cycles give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= 8'h00;
      end else if (bus_i.rd) begin
         rd_q <= 8'h00;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (hit(bus_i.addr, SPACE_A, OFF_CFG[ch])) begin
               rd_q <= cfg_q[ch];
            end
            if (hit(bus_i.addr, SPACE_A, OFF_REF[ch])) begin
               rd_q <= ref_q[ch];                        // [R6] [R13]
            end
            if (hit(bus_i.addr, SPACE_A, OFF_AVG[ch])) begin
               rd_q <= avg_q[ch];                        // [R7] [R9]
            end
            if (hit(bus_i.addr, SPACE_A, OFF_RES[ch])) begin
               rd_q <= res_q[ch];                        // [R8] [R10]
            end
         end
         if (hit(bus_i.addr, SPACE_B, OFF_TRIM)) begin
            rd_q <= {5'h00, trim_q};                     // [R1] [R11]
         end
      end else begin
         rd_q <= 8'h00;
      end
   end

   assign rd_data_o    = rd_q;
   assign amp_wake_o   = wake_q[CH_AMP];
   assign phase_wake_o = wake_q[CH_PHASE];

endmodule
`default_nettype wire

// >>> wpm_pkg.sv
`default_nettype none
package wpm_pkg;

   localparam int unsigned NUM_CH       = 2;
   localparam int unsigned CH_AMP       = 0;
   localparam int unsigned CH_PHASE     = 1;

   // address bit 6 selects register space B
   localparam int unsigned ADDR_SPACE_BIT = 6;
   localparam logic        SPACE_A        = 1'b0;
   localparam logic        SPACE_B        = 1'b1;

   // per channel offsets, index 0 amplitude, index 1 phase
   localparam logic [NUM_CH-1:0][5:0] OFF_CFG = {6'h37, 6'h33};
   localparam logic [NUM_CH-1:0][5:0] OFF_REF = {6'h38, 6'h34};
   localparam logic [NUM_CH-1:0][5:0] OFF_AVG = {6'h39, 6'h35};
   localparam logic [NUM_CH-1:0][5:0] OFF_RES = {6'h3a, 6'h36};
   localparam logic [5:0]             OFF_TRIM = 6'h39;

   // configuration field positions
   localparam int unsigned CFG_DELTA_HI = 7;
   localparam int unsigned CFG_DELTA_LO = 4;
   localparam int unsigned CFG_INCL     = 3;
   localparam int unsigned CFG_WGT_HI   = 2;
   localparam int unsigned CFG_WGT_LO   = 1;
   localparam int unsigned CFG_SRC      = 0;

   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] REF_RST  = 8'h00;
   localparam logic [7:0] AVG_RST  = 8'h00;
   localparam logic [7:0] RES_RST  = 8'h00;
   localparam logic [2:0] TRIM_RST = 3'h0;
   localparam logic [2:0] TRIM_CENTRE = 3'h3;
   localparam int unsigned TRIM_W  = 3;

   // weight code 0 means 4, i.e. a shift of two
   localparam logic [2:0] WGT_SHIFT_BASE = 3'h2;

   typedef struct packed {
      logic [3:0] delta;
      logic       incl;
      logic [1:0] weight;
      logic       src;
   } wpm_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] value;
   } wpm_meas_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } wpm_bus_t;

endpackage
`default_nettype wire

// >>> wpm_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wpm_regs_monitor
   import wpm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire wpm_bus_t    bus_i,
   input  wire logic [7:0]  rd_data_o,
   input  wire wpm_meas_t   amp_meas_i,
   input  wire wpm_meas_t   phase_meas_i,
   input  wire logic [2:0]  osc_trim_i,
   input  wire logic        amp_wake_o,
   input  wire logic        phase_wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] cfg_q;
   logic [7:0] ref_q;
   logic [7:0] acfg_q;
   logic [7:0] aref_q;
   logic [8:0] dif;
   logic [8:0] adif;
   logic       hit;
   logic       ahit;
   // shadow copies, since the checker cannot see the registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q  <= 8'h00;
         ref_q  <= 8'h00;
         acfg_q <= 8'h00;
         aref_q <= 8'h00;
      end else if (bus_i.wr) begin
         if (bus_i.addr == 7'h37) begin
            cfg_q <= bus_i.wdata;
         end
         if (bus_i.addr == 7'h38) begin
            ref_q <= bus_i.wdata;
         end
         if (bus_i.addr == 7'h33) begin
            acfg_q <= bus_i.wdata;
         end
         if (bus_i.addr == 7'h34) begin
            aref_q <= bus_i.wdata;
         end
      end
   end
   assign dif  = {1'b0, phase_meas_i.value} - {1'b0, ref_q};
   assign hit  = (dif[8] ? -dif : dif) > {5'h00, cfg_q[7:4]};
   assign adif = {1'b0, amp_meas_i.value} - {1'b0, aref_q};
   assign ahit = (adif[8] ? -adif : adif) > {5'h00, acfg_q[7:4]};
   a_phase_ref_rb: assert property (
      $past(bus_i.rd && bus_i.addr == 7'h38) |-> rd_data_o == ref_q)
      else $error("phase reference readback");
   a_amp_ref_rb: assert property (
      $past(bus_i.rd && bus_i.addr == 7'h34) |-> rd_data_o == aref_q)
      else $error("amp reference readback");
   a_phase_cfg_rb: assert property (
      $past(bus_i.rd && bus_i.addr == 7'h37) |-> rd_data_o == cfg_q)
      else $error("phase config readback");
   a_trim_read: assert property (
      $past(bus_i.rd && bus_i.addr == 7'h79)
      |-> rd_data_o == {5'h00, $past(osc_trim_i, 2)})
      else $error("trim readout");
   a_phase_result: assert property ($past(phase_meas_i.valid, 2)
      && $past(bus_i.rd && bus_i.addr == 7'h3a && !phase_meas_i.valid)
      |-> rd_data_o == $past(phase_meas_i.value, 2))
      else $error("phase result");
   a_amp_result: assert property ($past(amp_meas_i.valid, 2)
      && $past(bus_i.rd && bus_i.addr == 7'h36 && !amp_meas_i.valid)
      |-> rd_data_o == $past(amp_meas_i.value, 2))
      else $error("amp result");
   a_phase_cause: assert property (phase_wake_o
      |-> $past(phase_meas_i.valid)) else $error("phase wake without sample");
   a_amp_cause: assert property (amp_wake_o
      |-> $past(amp_meas_i.valid)) else $error("amp wake without sample");
   a_wake_thresh: assert property (
      $past(phase_meas_i.valid && !cfg_q[0])
      |-> phase_wake_o == $past(hit)) else $error("phase wake threshold");
   a_amp_thresh: assert property (
      $past(amp_meas_i.valid && !acfg_q[0])
      |-> amp_wake_o == $past(ahit)) else $error("amp wake threshold");
endmodule
bind wpm_regs wpm_regs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .bus_i(bus_i), .rd_data_o(rd_data_o), .amp_meas_i(amp_meas_i),
   .phase_meas_i(phase_meas_i), .osc_trim_i(osc_trim_i),
   .amp_wake_o(amp_wake_o), .phase_wake_o(phase_wake_o));
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR %0t got %h want %h", $time, a, e); end end
module tb
   import wpm_pkg::*;
;
   logic       clk_i = 0, rst_i = 1, rp = 0, vp = 0, aw, pw;
   wpm_bus_t   bus = '0;
   wpm_meas_t  am = '0, pm = '0;
   logic [2:0] trim = TRIM_CENTRE;
   logic [7:0] rd_data, x, avg[2] = '{default: 8'h00};
   logic [7:0] refv[2] = '{default: 8'h00}, cfg[2] = '{default: 8'h00};
   logic [1:0] y;
   logic [7:0] rq[$];
   logic [1:0] wq[$];
   int         err_total = 0, checks = 0, k;
   wpm_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
      .rd_data_o(rd_data), .amp_meas_i(am), .phase_meas_i(pm),
      .osc_trim_i(trim), .amp_wake_o(aw), .phase_wake_o(pw));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      rp <= bus.rd;
      vp <= am.valid | pm.valid;
   end
   // outputs settle by the falling edge
   always @(negedge clk_i) begin
      if (rp) begin
         x = rq.pop_front();
         `CHK(rd_data, x)
      end
      if (vp) begin
         y = wq.pop_front();
         `CHK({aw, pw}, y)
      end
   end
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic op(input logic [6:0] a, input logic [7:0] d,
                     input logic w, input logic [7:0] e);
      bus <= '{a, d, w, !w};
      if (!w) rq.push_back(e);
      @(posedge clk_i);
      bus <= '0;
      @(posedge clk_i);
   endtask
   // model uses values from before the update
   task automatic smp(input int c, input logic [7:0] v);
      logic signed [8:0] df;
      logic              hit;
      df = {1'b0, v} - {1'b0, cfg[c][0] ? avg[c] : refv[c]};
      hit = (df[8] ? -df : df) > {5'h00, cfg[c][7:4]};
      df = {1'b0, v} - {1'b0, avg[c]};
      if (!hit || cfg[c][3]) avg[c] = avg[c] + 8'(df >>> (cfg[c][2:1] + 2));
      wq.push_back(c ? {1'b0, hit} : {hit, 1'b0});
      if (c) pm <= '{1'b1, v}; else am <= '{1'b1, v};
      @(posedge clk_i);
      am <= '0;
      pm <= '0;
      op(c ? 7'h3a : 7'h36, 8'h00, 1'b0, v);
      op(c ? 7'h39 : 7'h35, 8'h00, 1'b0, avg[c]);
   endtask
   initial begin
      void'($urandom(17));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      op(7'h79, 8'h00, 1'b0, {5'h00, TRIM_CENTRE});
      for (k = 'h33; k <= 'h3a; k++) op(7'(k), 8'h00, 1'b0, 8'h00);
      op(7'h00, 8'h00, 1'b0, 8'h00);
      trim <= 3'($urandom);
      @(posedge clk_i);
      op(7'h79, 8'h00, 1'b0, {5'h00, trim});
      op(7'h39, 8'hff, 1'b1, 8'h00);
      op(7'h39, 8'h00, 1'b0, 8'h00);
      for (k = 0; k < 2; k++) begin
         refv[k] = 8'($urandom);
         op(k ? 7'h38 : 7'h34, refv[k], 1'b1, 8'h00);
         op(k ? 7'h38 : 7'h34, 8'h00, 1'b0, refv[k]);
         smp(0, refv[0] + 8'(k));
      end
      for (k = 0; k < 64; k++) begin
         if (k % 4 == 0) begin
            cfg[1] = {4'($urandom), 4'(k / 4)};
            op(7'h37, cfg[1], 1'b1, 8'h00);
            op(7'h37, 8'h00, 1'b0, cfg[1]);
            cfg[0] = {4'($urandom), 4'(15 - k / 4)};
            op(7'h33, cfg[0], 1'b1, 8'h00);
            op(7'h33, 8'h00, 1'b0, cfg[0]);
         end
         smp(1, k[0] ? 8'($urandom) : refv[1] + 8'($urandom % 20));
         smp(0, k[1] ? 8'($urandom) : refv[0] + 8'($urandom % 20));
      end
      // second reset at the end of the run: every space A register must read zero again
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (k = 'h33; k <= 'h3a; k++) op(7'(k), 8'h00, 1'b0, 8'h00);
      report_and_stop;
   end
   initial begin
      #100us;
      err_total++;
      report_and_stop;
   end
endmodule
`default_nettype wire
